// ---- shared/smsu_pkg.sv ----
// Purpose: constants and types of the supply monitor status unit
// Assumes: 8-bit register port, one clock
// Notes: none
// How it works
// - the synchronised warning comparator reads live at bit 1 and ignores writes.
// - only hardware sets or clears the warning flag: 1 below threshold, 0 above.
// - with the enable set, each rising or falling crossing raises an interrupt request.
// - the request reaches the cpu only with enable bit 0 set and the cpu mask clear.
// - entering the service routine clears the pending request with no register access.
// - in wait the unit runs on and a pending request wakes the device.
// - in halt the register contents freeze and the request cannot wake the device.
// - the warning threshold comes from bits 1:0 of the threshold register at 3Eh.
// - an undervoltage reset sets bit 2, and a read of the register outside halt clears it.
// - external or watchdog resets leave the undervoltage reset flag as it was.
// - with the undervoltage unit disabled the flag value is undefined to software.
// - on an internal clock a dip shorter than about 33us may reset without the flag.
// - on the external clock the flag stays clear in halt and needs above 10 MHz in run.
// - bits 6:5 hold the two low oscillator trim bits, written by software after reset.
package smsu_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int EVT_W = 3;
	localparam logic [ADDR_W-1:0] CTRL_STATUS_OFS = 8'h3A;
	localparam logic [ADDR_W-1:0] THRESH_SEL_OFS = 8'h3E;
	localparam logic [ADDR_W-1:0] EVT_STATUS_OFS = 8'h40;
	localparam logic [ADDR_W-1:0] EVT_MASK_OFS = 8'h41;
	localparam int IRQ_EN_BIT = 0;
	localparam int WARN_FLAG_BIT = 1;
	localparam int LVR_FLAG_BIT = 2;
	localparam int TRIM_LSB = 5;
	localparam int TRIM_MSB = 6;
	localparam int THRESH_LSB = 0;
	localparam int THRESH_MSB = 1;
	localparam int EVT_FALL_BIT = 0;
	localparam int EVT_RISE_BIT = 1;
	localparam int EVT_LVR_BIT = 2;
	localparam logic [1:0] TRIM_RESET = 2'h3;
	localparam logic [1:0] THRESH_RESET = 2'h3;
	localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	typedef enum logic [1:0] {
		LVR_CAPTURE = 2'b01,
		LVR_RUN = 2'b10
	} smsu_lvr_state_type;
endpackage : smsu_pkg

// ---- shared/smsu_sync_if.sv ----
// Purpose: synchronised comparator level and crossing events
// Assumes: single clock domain on both ends
// Notes: freeze stops level updates while halted
`timescale 1ns/100ps
interface smsu_sync_if;
	logic warnLevel;
	logic riseEvt;
	logic fallEvt;
	logic freeze;
	modport prod (output warnLevel, output riseEvt, output fallEvt, input freeze);
	modport cons (input warnLevel, input riseEvt, input fallEvt, output freeze);
endinterface : smsu_sync_if

// ---- design/smsu_sync.sv ----
// Purpose: comparator synchroniser and crossing detector
// Assumes: comparator output is asynchronous to mclk
// Notes: a change counts once second and third stages agree
`timescale 1ns/100ps
module smsu_sync (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cmpAsync,
	smsu_sync_if.prod sync
);
	import smsu_pkg::*;

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;
	logic level_reg;
	logic rise_reg;
	logic fall_reg;

	// ----------------------------------------
	// three stage synchroniser
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end else begin
			stage1_reg <= cmpAsync;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// ----------------------------------------
	// level and crossing events
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			level_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
			if (!sync.freeze && stage2_reg == stage3_reg && stage3_reg != level_reg) begin
				level_reg <= stage3_reg;
				rise_reg <= stage3_reg;
				fall_reg <= !stage3_reg;
			end
		end
	end

	assign sync.warnLevel = level_reg;
	assign sync.riseEvt = rise_reg;
	assign sync.fallEvt = fall_reg;
endmodule : smsu_sync

// ---- design/smsu_top.sv ----
// Purpose: supply monitor status, trim and interrupt registers
// Assumes: cpu drives halt, wait, mask and service acknowledge on mclk
// Notes: undervoltage flag survives warm resets, only rstn or a status register read clears it
`timescale 1ns/100ps
module smsu_top (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [smsu_pkg::ADDR_W-1:0] regAddr,
	input wire logic [smsu_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [smsu_pkg::DATA_W-1:0] regRdata,
	input wire logic cmpAsync,
	input wire logic warmReset,
	input wire logic lvrCause,
	input wire logic lvrEnable,
	input wire logic lvrShortDip,
	input wire logic extClkSel,
	input wire logic extClkFast,
	input wire logic haltMode,
	input wire logic waitMode,
	input wire logic cpuIntMask,
	input wire logic intAck,
	output logic cpuIrq,
	output logic waitWake,
	output logic [1:0] oscTrimLowBits,
	output logic [1:0] warnThresholdField,
	output logic irqOut
);
	import smsu_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	smsu_lvr_state_type lvrState_reg;
	logic [1:0] trim_reg;
	logic irqEnable_reg;
	logic lvrFlag_reg;
	logic [1:0] thresh_reg;
	logic warnPending_reg;
	logic cpuIrq_reg;
	logic waitWake_reg;
	logic [EVT_W-1:0] evtStatus_reg;
	logic [EVT_W-1:0] evtMask_reg;
	logic irqOut_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic lvrSet;
	logic crossEvt;
	logic ctrlWr;
	logic ctrlRd;
	logic [EVT_W-1:0] evtSet;

	smsu_sync_if syncBus ();

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hitWr(input logic [ADDR_W-1:0] ofs);
		hitWr = regWr && regAddr == ofs && !haltMode;
	endfunction : hitWr

	function automatic logic lvrQualifies(
		input logic extSel,
		input logic fast,
		input logic halted,
		input logic shortDip
	);
		if (extSel) begin
			lvrQualifies = fast && !halted;
		end else begin
			lvrQualifies = !shortDip;
		end
	endfunction : lvrQualifies

	// ----------------------------------------
	// comparator synchroniser
	// ----------------------------------------
	smsu_sync syncUnit (
		.mclk(mclk),
		.rstn(rstn),
		.cmpAsync(cmpAsync),
		.sync(syncBus.prod)
	);

	assign syncBus.freeze = haltMode;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign ctrlWr = hitWr(CTRL_STATUS_OFS);
	assign ctrlRd = regRd && regAddr == CTRL_STATUS_OFS && !haltMode;
	assign crossEvt = syncBus.riseEvt || syncBus.fallEvt;
	assign lvrSet = lvrState_reg == LVR_CAPTURE && lvrCause
		&& lvrQualifies(extClkSel, extClkFast, haltMode, lvrShortDip);

	// ----------------------------------------
	// reset cause capture
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lvrState_reg <= LVR_CAPTURE;
		end else begin
			case (lvrState_reg)
				LVR_CAPTURE: begin
					lvrState_reg <= LVR_RUN;
				end
				LVR_RUN: begin
					if (warmReset) begin
						lvrState_reg <= LVR_CAPTURE;
					end
				end
				default: begin
					lvrState_reg <= LVR_CAPTURE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// undervoltage reset flag
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lvrFlag_reg <= 1'b0;
		end else if (lvrSet) begin
			lvrFlag_reg <= 1'b1;
		end else if (ctrlRd) begin
			lvrFlag_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// control bits and threshold
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			trim_reg <= TRIM_RESET;
			irqEnable_reg <= 1'b0;
		end else if (warmReset) begin
			trim_reg <= TRIM_RESET;
			irqEnable_reg <= 1'b0;
		end else if (ctrlWr) begin
			trim_reg <= regWdata[TRIM_MSB:TRIM_LSB];
			irqEnable_reg <= regWdata[IRQ_EN_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			thresh_reg <= THRESH_RESET;
		end else if (warmReset) begin
			thresh_reg <= THRESH_RESET;
		end else if (hitWr(THRESH_SEL_OFS)) begin
			thresh_reg <= regWdata[THRESH_MSB:THRESH_LSB];
		end
	end

	// ----------------------------------------
	// warning interrupt
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			warnPending_reg <= 1'b0;
		end else if (warmReset) begin
			warnPending_reg <= 1'b0;
		end else if (crossEvt && irqEnable_reg) begin
			warnPending_reg <= 1'b1;
		end else if (intAck) begin
			warnPending_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cpuIrq_reg <= 1'b0;
			waitWake_reg <= 1'b0;
		end else begin
			cpuIrq_reg <= warnPending_reg && irqEnable_reg && !cpuIntMask;
			waitWake_reg <= warnPending_reg && irqEnable_reg && waitMode
				&& !haltMode;
		end
	end

	// ----------------------------------------
	// event status and mask
	// ----------------------------------------
	always_comb begin
		evtSet = EVT_RESET;
		evtSet[EVT_FALL_BIT] = syncBus.riseEvt;
		evtSet[EVT_RISE_BIT] = syncBus.fallEvt;
		evtSet[EVT_LVR_BIT] = lvrSet;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			evtStatus_reg <= EVT_RESET;
		end else if (hitWr(EVT_STATUS_OFS)) begin
			evtStatus_reg <= (evtStatus_reg & ~regWdata[EVT_W-1:0]) | evtSet;
		end else begin
			evtStatus_reg <= evtStatus_reg | evtSet;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			evtMask_reg <= EVT_RESET;
		end else if (hitWr(EVT_MASK_OFS)) begin
			evtMask_reg <= regWdata[EVT_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irqOut_reg <= 1'b0;
		end else begin
			irqOut_reg <= |(evtStatus_reg & evtMask_reg);
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb begin
		rdata_next = READ_ZERO;
		case (regAddr)
			CTRL_STATUS_OFS: begin
				rdata_next[TRIM_MSB:TRIM_LSB] = trim_reg;
				rdata_next[LVR_FLAG_BIT] = lvrFlag_reg && lvrEnable;
				rdata_next[WARN_FLAG_BIT] = syncBus.warnLevel;
				rdata_next[IRQ_EN_BIT] = irqEnable_reg;
			end
			THRESH_SEL_OFS: begin
				rdata_next[THRESH_MSB:THRESH_LSB] = thresh_reg;
			end
			EVT_STATUS_OFS: begin
				rdata_next[EVT_W-1:0] = evtStatus_reg;
			end
			EVT_MASK_OFS: begin
				rdata_next[EVT_W-1:0] = evtMask_reg;
			end
			default: begin
				rdata_next = READ_ZERO;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= READ_ZERO;
		end else if (regRd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= READ_ZERO;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign regRdata = rdata_reg;
	assign cpuIrq = cpuIrq_reg;
	assign waitWake = waitWake_reg;
	assign oscTrimLowBits = trim_reg;
	assign warnThresholdField = thresh_reg;
	assign irqOut = irqOut_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	warnFlagRead_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		regRd && regAddr == CTRL_STATUS_OFS
		|=> rdata_reg[WARN_FLAG_BIT] == $past(syncBus.warnLevel))
		else $error("warning flag read mismatch");

	warnHwOnly_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		!syncBus.riseEvt && !syncBus.fallEvt |-> $stable(syncBus.warnLevel))
		else $error("warning flag changed without a crossing");

	crossPending_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		crossEvt && irqEnable_reg && !warmReset |=> warnPending_reg)
		else $error("crossing did not raise a request");

	cpuIrqGate_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		cpuIrq_reg |-> $past(warnPending_reg) && $past(irqEnable_reg) && !$past(cpuIntMask))
		else $error("cpu request without enable or with mask");

	ackClear_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		intAck && !(crossEvt && irqEnable_reg) ##1 !crossEvt |=> !cpuIrq_reg)
		else $error("acknowledge did not clear request");

	waitWake_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		waitMode && !haltMode && warnPending_reg && irqEnable_reg |=> waitWake_reg)
		else $error("pending request did not wake from wait");

	haltFreeze_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		haltMode && !warmReset |=> $stable(trim_reg) && $stable(irqEnable_reg)
			&& $stable(syncBus.warnLevel) && !waitWake_reg)
		else $error("state changed during halt");

	threshWrite_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		hitWr(THRESH_SEL_OFS) && !warmReset
		|=> thresh_reg == $past(regWdata[THRESH_MSB:THRESH_LSB]))
		else $error("threshold write lost");

	lvrReadClear_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		ctrlRd && !lvrSet |=> !lvrFlag_reg)
		else $error("read did not clear undervoltage flag");

	lvrWarmKeep_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		warmReset && lvrFlag_reg && !ctrlRd |=> lvrFlag_reg)
		else $error("warm reset cleared undervoltage flag");

	lvrExtHalt_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		extClkSel && haltMode && !lvrFlag_reg |=> !lvrFlag_reg)
		else $error("undervoltage flag set in halt on external clock");

	trimWrite_a: assert property (
		@(posedge mclk) disable iff (!rstn)
		ctrlWr && !warmReset |=> trim_reg == $past(regWdata[TRIM_MSB:TRIM_LSB]))
		else $error("trim bits write lost");
endmodule : smsu_top

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the supply monitor status unit
// Assumes: register port answers one cycle after the read strobe
// Notes: scenarios run in sequence from one power-on reset
`timescale 1ns/100ps
module testbench;
	import smsu_pkg::*;
	logic mclk, rstn, regWr, regRd, cmpAsync, warmReset, lvrCause, lvrEnable;
	logic lvrShortDip, extClkSel, extClkFast, haltMode, waitMode, cpuIntMask, intAck;
	logic [7:0] regAddr, regWdata, regRdata;
	logic cpuIrq, waitWake, irqOut;
	logic [1:0] oscTrimLowBits, warnThresholdField;
	int badCount = 0;
	int nCompared = 0;

	smsu_top dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cmpAsync(cmpAsync),
		.warmReset(warmReset), .lvrCause(lvrCause), .lvrEnable(lvrEnable),
		.lvrShortDip(lvrShortDip), .extClkSel(extClkSel), .extClkFast(extClkFast),
		.haltMode(haltMode), .waitMode(waitMode), .cpuIntMask(cpuIntMask), .intAck(intAck),
		.cpuIrq(cpuIrq), .waitWake(waitWake), .oscTrimLowBits(oscTrimLowBits),
		.warnThresholdField(warnThresholdField), .irqOut(irqOut));

	always #2 mclk = ~mclk;

	// ----------------------------------------
	// compare and bus helpers
	// ----------------------------------------
	task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		nCompared++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk8

	task chk1(input logic got, input logic exp, input string what);
		nCompared++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk1

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		chk8(regRdata, exp, what);
	endtask : rdchk

	task waitOn(input int which, input logic want, input string what);
		int n;
		logic v;
		n = 0;
		v = ~want;
		while (n < 16 && v !== want) begin
			@(posedge mclk);
			#1;
			v = (which == 0) ? cpuIrq : (which == 1) ? waitWake : irqOut;
			n++;
		end
		chk1(v, want, what);
	endtask : waitOn

	task setCmp(input logic v);
		@(posedge mclk);
		cmpAsync <= v;
	endtask : setCmp

	task ack;
		@(posedge mclk);
		intAck <= 1'b1;
		@(posedge mclk);
		intAck <= 1'b0;
	endtask : ack

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task tResetFlag;
		@(posedge mclk);
		warmReset <= 1'b1;
		@(posedge mclk);
		warmReset <= 1'b0;
		repeat (3) @(posedge mclk);
		rdchk(CTRL_STATUS_OFS, 8'h64, "flag kept over warm reset");
		rdchk(CTRL_STATUS_OFS, 8'h60, "flag cleared by read");
		rdchk(THRESH_SEL_OFS, 8'h03, "threshold reset");
		chk8({6'h00, oscTrimLowBits}, 8'h03, "trim reset");
	endtask : tResetFlag

	task tLvrQual;
		logic [5:0] tbl [6];
		tbl = '{6'b000101, 6'b001100, 6'b100100, 6'b110101, 6'b110110, 6'b000000};
		foreach (tbl[i]) begin
			@(posedge mclk);
			extClkSel <= tbl[i][5];
			extClkFast <= tbl[i][4];
			lvrShortDip <= tbl[i][3];
			lvrEnable <= tbl[i][2];
			haltMode <= tbl[i][1];
			warmReset <= 1'b1;
			lvrCause <= 1'b1;
			@(posedge mclk);
			warmReset <= 1'b0;
			repeat (2) @(posedge mclk);
			lvrCause <= 1'b0;
			haltMode <= 1'b0;
			rdchk(CTRL_STATUS_OFS, {5'h0C, tbl[i][0], 2'h0}, "qualified flag");
		end
		@(posedge mclk);
		lvrEnable <= 1'b1;
		extClkSel <= 1'b0;
		extClkFast <= 1'b0;
		rdchk(CTRL_STATUS_OFS, 8'h60, "flag after cleanup read");
	endtask : tLvrQual

	task tRegs;
		wr(CTRL_STATUS_OFS, 8'h63);
		rdchk(CTRL_STATUS_OFS, 8'h61, "read-only and reserved bits");
		wr(CTRL_STATUS_OFS, 8'h20);
		rdchk(CTRL_STATUS_OFS, 8'h20, "trim write");
		chk8({6'h00, oscTrimLowBits}, 8'h01, "trim output");
		wr(THRESH_SEL_OFS, 8'hFE);
		rdchk(THRESH_SEL_OFS, 8'h02, "threshold write");
		chk8({6'h00, warnThresholdField}, 8'h02, "threshold output");
		wr(8'h55, 8'hFF);
		rdchk(8'h55, 8'h00, "unmapped read");
	endtask : tRegs

	task tIrq;
		wr(CTRL_STATUS_OFS, 8'h01);
		setCmp(1'b1);
		waitOn(0, 1'b1, "irq on supply drop");
		rdchk(CTRL_STATUS_OFS, 8'h03, "warning flag set");
		ack();
		waitOn(0, 1'b0, "irq cleared by service entry");
		setCmp(1'b0);
		waitOn(0, 1'b1, "irq on recovery");
		rdchk(CTRL_STATUS_OFS, 8'h01, "warning flag clear");
		ack();
		waitOn(0, 1'b0, "irq cleared again");
		@(posedge mclk);
		cpuIntMask <= 1'b1;
		setCmp(1'b1);
		repeat (12) @(posedge mclk);
		#1;
		chk1(cpuIrq, 1'b0, "irq held by cpu mask");
		@(posedge mclk);
		cpuIntMask <= 1'b0;
		waitOn(0, 1'b1, "irq after unmask");
		ack();
		wr(CTRL_STATUS_OFS, 8'h00);
		setCmp(1'b0);
		repeat (12) @(posedge mclk);
		#1;
		chk1(cpuIrq, 1'b0, "no irq when disabled");
	endtask : tIrq

	task tWaitHalt;
		wr(CTRL_STATUS_OFS, 8'h01);
		@(posedge mclk);
		waitMode <= 1'b1;
		setCmp(1'b1);
		waitOn(1, 1'b1, "wake from wait");
		@(posedge mclk);
		haltMode <= 1'b1;
		waitOn(1, 1'b0, "no wake in halt with request pending");
		ack();
		wr(CTRL_STATUS_OFS, 8'h60);
		setCmp(1'b0);
		repeat (12) @(posedge mclk);
		#1;
		chk1(waitWake, 1'b0, "wake cleared");
		chk1(cpuIrq, 1'b0, "no irq in halt");
		rdchk(CTRL_STATUS_OFS, 8'h03, "frozen in halt");
		@(posedge mclk);
		waitMode <= 1'b0;
		haltMode <= 1'b0;
		waitOn(0, 1'b1, "crossing after halt exit");
		rdchk(CTRL_STATUS_OFS, 8'h01, "flag after halt exit");
		ack();
	endtask : tWaitHalt

	task tEvents;
		rdchk(EVT_STATUS_OFS, 8'h07, "all events recorded");
		wr(EVT_STATUS_OFS, 8'h07);
		wr(EVT_MASK_OFS, 8'h03);
		waitOn(2, 1'b0, "event line idle");
		setCmp(1'b1);
		waitOn(2, 1'b1, "event line on drop");
		rdchk(EVT_STATUS_OFS, 8'h01, "drop event status");
		wr(EVT_MASK_OFS, 8'h02);
		waitOn(2, 1'b0, "event masked");
		wr(EVT_MASK_OFS, 8'h03);
		waitOn(2, 1'b1, "event unmasked");
		wr(EVT_STATUS_OFS, 8'h01);
		waitOn(2, 1'b0, "event cleared");
		rdchk(EVT_STATUS_OFS, 8'h00, "status empty");
	endtask : tEvents

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task reportAndStop;
		if (badCount == 0 && nCompared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : reportAndStop

	initial begin
		#40000;
		badCount++;
		reportAndStop();
	end

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		cmpAsync = 1'b0;
		warmReset = 1'b0;
		lvrCause = 1'b1;
		lvrEnable = 1'b1;
		lvrShortDip = 1'b0;
		extClkSel = 1'b0;
		extClkFast = 1'b0;
		haltMode = 1'b0;
		waitMode = 1'b0;
		cpuIntMask = 1'b0;
		intAck = 1'b0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		lvrCause <= 1'b0;
		tResetFlag();
		tLvrQual();
		tRegs();
		tIrq();
		tWaitHalt();
		tEvents();
		reportAndStop();
	end
endmodule : testbench
